/* File: common/adc_ctrl_pkg.sv */
/*
  Constants, types and helpers for the converter control block.
  Assumes an 8-bit register port and a single system clock.
*/
// What this block does
// - two-bit field picks reference: supply, external pin or amplifier output
// - reference code 00 supply, 01 external pin, 1x amplifier output
// - amplifier powered only while its enable bit is set
// - two-bit gain field picks gain 1, 1.667, 2.5 or 3.333
// - one bit routes amplifier input from reference pin or bandgap
// - internal reference chosen means external reference pin disconnected; amplifier input pin follows its own bit
// - analog function on a pin disables its digital functions
// - analog function on a pin disconnects its pull-high resistor
// - analog function on a pin overrides its direction control
// - source codes 0000, 0100, 11xx convert the selected external channel
// - channel 0000..1011 connects that channel; 1100..1111 connects none
// - internal source selected switches every external channel off
// - internal codes: supply /1 /2 /4, amplifier /1 /2 /4, 10xx ground
// - start bit low-high-low begins a conversion after the falling edge
// - busy set when conversion starts, cleared when it completes
// - completion sets interrupt flag and raises request when enabled
// - three-bit divider code 000 gives /1, each step doubles to /128
// - converter powered only while its power-enable bit is high
// - conversion lasts 16 conversion clocks: 4 sampling, 12 converting
package adc_ctrl_pkg;
  localparam int N_CHAN = 12;
  localparam int RES_W = 12;
  localparam int SAMPLE_CLKS = 4;
  localparam int CONV_CLKS = 12;
  localparam int CLK_NS = 50;
  localparam int CONVERSION_CLOCK_PERIOD_MIN_NS = 500;
  localparam int ADCK_MIN_DIV = (CONVERSION_CLOCK_PERIOD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWR_UP_CLKS = 20;

  localparam logic [3:0] A_CTRL_A = 4'h0;
  localparam logic [3:0] A_CTRL_B = 4'h1;
  localparam logic [3:0] A_CTRL_C = 4'h2;
  localparam logic [3:0] A_PIN_LO = 4'h3;
  localparam logic [3:0] A_PIN_HI = 4'h4;
  localparam logic [3:0] A_STAT = 4'h5;
  localparam logic [3:0] A_RES_LO = 4'h6;
  localparam logic [3:0] A_RES_HI = 4'h7;

  localparam int CA_START = 7;
  localparam int CA_BUSY = 6;
  localparam int CA_PWR = 5;
  localparam int CA_CHAN_LSB = 0;
  localparam int CB_SRC_LSB = 4;
  localparam int CB_DIV_LSB = 0;
  localparam int CC_AMP_EN = 7;
  localparam int CC_AMP_IN = 4;
  localparam int CC_REF_LSB = 2;
  localparam int CC_GAIN_LSB = 0;
  localparam int ST_FLAG = 0;
  localparam int ST_IE = 1;

  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_CTRL_C = 8'h00;
  localparam logic [11:0] RST_PIN_FN = 12'h000;
  localparam logic [11:0] SAR_FIRST = 12'h800;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONVERT = 2'b11
  } conv_state_t;

  function automatic logic src_is_ext(input logic [3:0] src);
    return (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'b11);
  endfunction
endpackage

/* File: common/ckdiv_if.sv */
/*
  Link between the control block and its conversion clock divider.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface ckdiv_if;
  logic [2:0] div_sel;
  logic tick;
  modport master (output div_sel, input tick);
  modport divider (input div_sel, output tick);
endinterface

/* File: hw/conv_clk_div.sv */
/*
  Free-running conversion clock divider giving a one-cycle tick.
  Assumes div_sel comes from a register on the same clock.
*/
`timescale 1ns/1ps
module conv_clk_div
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // divider link
  ckdiv_if.divider dv
);
  typedef struct packed {
    logic [6:0] cnt;
  } div_state_t;

  div_state_t q, d;
  logic [6:0] mask;

  always_comb begin
    d = q;
    d.cnt = q.cnt + 7'h01;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // low div_sel bits of the counter all ones: /1 .. /128
  assign mask = 7'((8'h01 << dv.div_sel) - 8'h01);
  assign dv.tick = ce && ((q.cnt & mask) == mask);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_div_slow;
    (dv.tick && dv.div_sel == 3'h7) |=> (!dv.tick || dv.div_sel != 3'h7) [*8];
  endproperty
  a_div_slow: assert property (p_div_slow) else $error("divide by 128 ticked early");

  property p_div_fast;
    (ce && dv.div_sel == 3'h0) |-> dv.tick;
  endproperty
  a_div_fast: assert property (p_div_fast) else $error("undivided clock missed a tick");
endmodule // conv_clk_div

/* File: hw/adc_ctrl.sv */
/*
  Register file, input routing, reference selection and conversion
  sequencer for one 12-bit successive-approximation converter.
  Assumes a same-clock register master and an asynchronous comparator.
*/
`timescale 1ns/1ps
module adc_ctrl
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // converter core
  input wire logic cmp_in,
  output logic conv_power_en,
  output logic sample_en,
  output logic conversion_busy_flag,
  output logic [11:0] sar_code,
  // reference path
  output logic ref_avdd_sel,
  output logic ref_pin_sel,
  output logic ref_amp_sel,
  output logic ref_pin_connect,
  output logic gain_amp_enable,
  output logic [1:0] gain_amp_gain_select,
  output logic amp_in_pin_connect,
  output logic amp_in_bandgap_sel,
  // input routing
  output logic [11:0] chan_en,
  output logic int_src_en,
  output logic int_src_amp,
  output logic [1:0] int_src_div,
  output logic int_src_gnd,
  // pin overrides
  output logic [11:0] pin_digital_off,
  output logic [11:0] pin_pullup_off,
  output logic [11:0] pin_dir_override,
  // completion
  output logic irq_flag,
  output logic irq_req
);
  typedef struct packed {
    logic [7:0] ca;
    logic [7:0] cb;
    logic [7:0] cc;
    logic [11:0] pin_fn;
    logic flag;
    logic ie;
    conv_state_t st;
    logic [3:0] cnt;
    logic [11:0] sar;
    logic [11:0] res;
    logic start_prev;
    logic cmp_s1;
    logic cmp_s2;
    logic [7:0] rdata;
  } ctrl_state_t;

  localparam ctrl_state_t STATE_RST = '{
    ca: RST_CTRL_A, cb: RST_CTRL_B, cc: RST_CTRL_C, pin_fn: RST_PIN_FN,
    flag: 1'b0, ie: 1'b0, st: ST_IDLE, cnt: 4'h0, sar: 12'h000,
    res: 12'h000, start_prev: 1'b0, cmp_s1: 1'b0, cmp_s2: 1'b0,
    rdata: 8'h00
  };

  ctrl_state_t q, d;
  ckdiv_if cd ();

  logic tick;
  logic pwr;
  logic busy;
  logic start_rise;
  logic start_fall;
  logic done;
  logic [3:0] src;
  logic [1:0] rsel;
  logic ext_sel;

  conv_clk_div u_div (
    .clk_sys (clk_sys),
    .nrst (nrst),
    .ce (ce),
    .dv (cd.divider)
  );

  assign cd.div_sel = q.cb[CB_DIV_LSB +: 3];
  assign tick = cd.tick;
  assign pwr = q.ca[CA_PWR];
  assign busy = (q.st == ST_SAMPLE) || (q.st == ST_CONVERT);
  assign start_rise = q.ca[CA_START] && !q.start_prev;
  assign start_fall = !q.ca[CA_START] && q.start_prev;
  assign src = q.cb[CB_SRC_LSB +: 4];
  assign rsel = q.cc[CC_REF_LSB +: 2];
  assign ext_sel = src_is_ext(src);

  always_comb begin
    logic [3:0] bi;
    bi = 4'(CONV_CLKS - 1) - q.cnt;
    d = q;
    done = 1'b0;
    d.cmp_s1 = cmp_in;
    d.cmp_s2 = q.cmp_s1;
    d.start_prev = q.ca[CA_START];
    d.rdata = 8'h00;

    if (wr_stb) begin
      case (addr)
        A_CTRL_A: d.ca = wdata;
        A_CTRL_B: d.cb = wdata;
        A_CTRL_C: d.cc = wdata;
        A_PIN_LO: d.pin_fn[7:0] = wdata;
        A_PIN_HI: d.pin_fn[11:8] = wdata[3:0];
        A_STAT: begin
          if (wdata[ST_FLAG]) begin
            d.flag = 1'b0;
          end
          d.ie = wdata[ST_IE];
        end
        default: ;
      endcase
    end

    if (rd_stb) begin
      case (addr)
        A_CTRL_A: begin
          d.rdata = q.ca;
          d.rdata[CA_BUSY] = busy;
        end
        A_CTRL_B: d.rdata = q.cb;
        A_CTRL_C: d.rdata = q.cc;
        A_PIN_LO: d.rdata = q.pin_fn[7:0];
        A_PIN_HI: d.rdata = {4'h0, q.pin_fn[11:8]};
        A_STAT: d.rdata = {6'h00, q.ie, q.flag};
        A_RES_LO: d.rdata = q.res[7:0];
        A_RES_HI: d.rdata = {4'h0, q.res[11:8]};
        default: d.rdata = 8'h00;
      endcase
    end

    if (start_rise) begin
      d.st = ST_ARMED;
      d.cnt = 4'h0;
    end else if (!pwr && q.st != ST_IDLE) begin
      d.st = ST_IDLE;
    end else begin
      case (q.st)
        ST_IDLE: ;
        ST_ARMED: begin
          if (start_fall) begin
            d.st = ST_SAMPLE;
            d.cnt = 4'h0;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (q.cnt == 4'(SAMPLE_CLKS - 1)) begin
              d.st = ST_CONVERT;
              d.cnt = 4'h0;
              d.sar = SAR_FIRST;
            end else begin
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            d.sar[bi] = q.cmp_s2;
            if (q.cnt == 4'(CONV_CLKS - 1)) begin
              done = 1'b1;
              d.res = d.sar;
              d.st = ST_IDLE;
              d.flag = 1'b1;
            end else begin
              d.sar[bi - 4'h1] = 1'b1;
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        default: d.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= STATE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // register port and converter core
  assign rdata = q.rdata;
  assign conv_power_en = pwr;
  assign sample_en = (q.st == ST_SAMPLE);
  assign conversion_busy_flag = busy;
  assign sar_code = q.sar;

  // reference selection
  assign ref_avdd_sel = (rsel == 2'b00);
  assign ref_pin_sel = (rsel == 2'b01);
  assign ref_amp_sel = rsel[1];
  assign ref_pin_connect = (rsel == 2'b01);
  assign gain_amp_enable = q.cc[CC_AMP_EN];
  assign gain_amp_gain_select = q.cc[CC_GAIN_LSB +: 2];
  assign amp_in_bandgap_sel = q.cc[CC_AMP_IN];
  assign amp_in_pin_connect = !q.cc[CC_AMP_IN];

  // internal source routing
  assign int_src_en = !ext_sel;
  assign int_src_gnd = (src[3:2] == 2'b10);
  assign int_src_amp = src[2];
  assign int_src_div = src[1:0];

  for (genvar i = 0; i < N_CHAN; i++) begin : g_pin
    assign chan_en[i] = ext_sel && (q.ca[CA_CHAN_LSB +: 4] == 4'(i));
    assign pin_digital_off[i] = q.pin_fn[i];
    assign pin_pullup_off[i] = q.pin_fn[i];
    assign pin_dir_override[i] = q.pin_fn[i];
  end

  assign irq_flag = q.flag;
  assign irq_req = q.flag && q.ie;

  // assertion helpers
  logic [4:0] busy_ticks;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_ticks <= 5'h00;
    end else if (!busy) begin
      busy_ticks <= 5'h00;
    end else if (tick) begin
      busy_ticks <= busy_ticks + 5'h01;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_conv_len;
    done |-> (busy_ticks == 5'(SAMPLE_CLKS + CONV_CLKS - 1));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion not 16 clocks");

  property p_done_flag;
    (done && ce) |=> (irq_flag && !conversion_busy_flag);
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("completion left flag or busy");

  property p_res_first;
    (ce && $rose(irq_flag)) |-> (q.res == $past(d.res));
  endproperty
  a_res_first: assert property (p_res_first) else $error("result late vs flag");

  property p_start_fall;
    (ce && q.st == ST_ARMED && start_fall && pwr && !start_rise) |=>
      (conversion_busy_flag && sample_en);
  endproperty
  a_start_fall: assert property (p_start_fall) else $error("falling start did not begin");

  property p_rise_reset;
    (ce && start_rise) |=> !conversion_busy_flag;
  endproperty
  a_rise_reset: assert property (p_rise_reset) else $error("rising start did not reset");

  property p_pwr_off;
    (ce && !conv_power_en) |=> (!conversion_busy_flag || conv_power_en);
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("busy while powered off");

  property p_int_off;
    !src_is_ext(q.cb[CB_SRC_LSB +: 4]) |-> (chan_en == 12'h000);
  endproperty
  a_int_off: assert property (p_int_off) else $error("channel on with internal source");

  property p_chan_sel;
    src_is_ext(src) |-> (q.ca[3:0] < 4'hC ? $onehot(chan_en) : chan_en == 12'h000);
  endproperty
  a_chan_sel: assert property (p_chan_sel) else $error("external channel decode wrong");

  property p_ref_pin;
    (q.cc[3:2] != 2'b01) |-> !ref_pin_connect && (ref_amp_sel || ref_avdd_sel);
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference pin left connected");

  property p_pin_ovr;
    (pin_pullup_off == pin_digital_off) && (pin_dir_override == q.pin_fn);
  endproperty
  a_pin_ovr: assert property (p_pin_ovr) else $error("pin override mismatch");

  // completion flag, busy readback, result, sampling length and re-arm
  property p_flag_hold;
    (irq_flag && !(wr_stb && addr == A_STAT && wdata[ST_FLAG])) |=> irq_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

  property p_busy_read;
    (ce && rd_stb && addr == A_CTRL_A) |=> (rdata[CA_BUSY] == $past(conversion_busy_flag));
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit read back wrong");

  property p_res_stable;
    !done |=> $stable(q.res);
  endproperty
  a_res_stable: assert property (p_res_stable) else $error("result moved mid-conversion");

  property p_sample_len;
    (busy && !sample_en) |-> (busy_ticks >= 5'(SAMPLE_CLKS));
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling cut short");

  property p_rise_arm;
    (ce && start_rise) |=> (q.st == ST_ARMED);
  endproperty
  a_rise_arm: assert property (p_rise_arm) else $error("rising start did not re-arm");

  // routing and reference sanity
  property p_gnd_src;
    (src[3:2] == 2'b10) |-> (int_src_en && int_src_gnd && chan_en == 12'h000);
  endproperty
  a_gnd_src: assert property (p_gnd_src) else $error("ground source routed wrong");

  property p_amp_in;
    amp_in_pin_connect != amp_in_bandgap_sel;
  endproperty
  a_amp_in: assert property (p_amp_in) else $error("amplifier input not exclusive");

  c_done: cover property (done);
  c_restart: cover property (busy && start_rise);
  c_int_conv: cover property (done && int_src_en);
  c_pwr_abort: cover property (busy && !pwr);
  c_slow_div: cover property (done && cd.div_sel == 3'h7);
endmodule // adc_ctrl

/* File: tb/adc_input_ref_and_sequencing_bench.sv */
/*
  Self-checking bench for the converter control block: routing, reference,
  pin override tables and the conversion handshake, driven over the register port.
  Assumes the package of the block and a 20 MHz system clock.
*/
`timescale 1ns/1ps
module adc_input_ref_and_sequencing_bench
  import adc_ctrl_pkg::*;
;
  logic clk_sys, nrst, ce, wr_stb, rd_stb, cmp_in;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic conv_power_en, sample_en, conversion_busy_flag;
  logic [11:0] sar_code, chan_en, pin_digital_off, pin_pullup_off, pin_dir_override;
  logic ref_avdd_sel, ref_pin_sel, ref_amp_sel, ref_pin_connect, gain_amp_enable;
  logic [1:0] gain_amp_gain_select, int_src_div;
  logic amp_in_pin_connect, amp_in_bandgap_sel, int_src_en, int_src_amp, int_src_gnd;
  logic irq_flag, irq_req, model_on, cmp_fix, ext;
  logic [11:0] vin;
  logic [3:0] s4, c4;
  int miscompares, cmp_count, cyc;

  adc_ctrl uut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cmp_in(cmp_in),
    .conv_power_en(conv_power_en), .sample_en(sample_en),
    .conversion_busy_flag(conversion_busy_flag), .sar_code(sar_code),
    .ref_avdd_sel(ref_avdd_sel), .ref_pin_sel(ref_pin_sel), .ref_amp_sel(ref_amp_sel),
    .ref_pin_connect(ref_pin_connect), .gain_amp_enable(gain_amp_enable),
    .gain_amp_gain_select(gain_amp_gain_select), .amp_in_pin_connect(amp_in_pin_connect),
    .amp_in_bandgap_sel(amp_in_bandgap_sel), .chan_en(chan_en), .int_src_en(int_src_en),
    .int_src_amp(int_src_amp), .int_src_div(int_src_div), .int_src_gnd(int_src_gnd),
    .pin_digital_off(pin_digital_off), .pin_pullup_off(pin_pullup_off),
    .pin_dir_override(pin_dir_override), .irq_flag(irq_flag), .irq_req(irq_req));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // analog input seen by the comparator against the trial code
  always @(posedge clk_sys) begin
    cmp_in <= model_on ? (vin >= sar_code) : cmp_fix;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
  endtask

  // one full conversion; length bounds follow the free-running divider phase
  task automatic conv(input logic [2:0] dv, input logic ie, input logic [11:0] expv);
    int n, s, p;
    logic [7:0] v;
    p = 1 << dv;
    wr(A_STAT, {6'h00, ie, 1'b1});
    wr(A_CTRL_B, {5'h00, dv});
    @(negedge clk_sys);
    chk(irq_flag, 1'b0);
    wr(A_CTRL_A, 8'h20);
    repeat (PWR_UP_CLKS) @(posedge clk_sys);
    wr(A_CTRL_A, 8'hA0);
    wr(A_CTRL_A, 8'h20);
    @(negedge clk_sys);
    chk(conversion_busy_flag, 1'b0);
    @(negedge clk_sys);
    chk({conversion_busy_flag, sample_en, conv_power_en}, 3'b111);
    n = 0;
    s = 0;
    while (conversion_busy_flag === 1'b1 && n < 3000) begin
      n++;
      s += int'(sample_en);
      @(negedge clk_sys);
    end
    chk(irq_flag, 1'b1);
    chk(irq_req, ie);
    chk(sar_code, expv);
    chk(n >= 15 * p + 1 && n <= 16 * p, 1'b1);
    chk(s >= 3 * p + 1 && s <= 4 * p, 1'b1);
    rd(A_RES_LO, v);
    chk(v, expv[7:0]);
    rd(A_RES_HI, v);
    chk(v, {4'h0, expv[11:8]});
    rd(A_STAT, v);
    chk(v, {6'h00, ie, 1'b1});
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    model_on = 1'b0;
    cmp_fix = 1'b1;
    vin = 12'hA5C;
    miscompares = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk({rdata, conversion_busy_flag, conv_power_en, irq_flag}, 11'h000);
    chk(chan_en, 12'h001);
    chk({ref_avdd_sel, amp_in_pin_connect, gain_amp_enable}, 3'b110);
    rd(4'h9, d);
    chk(d, 8'h00);
    wr(4'hA, 8'hFF);
    rd(A_STAT, d);
    chk(d, 8'h00);
    @(negedge clk_sys);
    chk(rdata, 8'h00);

    // pin functions set up before any reference pin is used
    wr(A_PIN_LO, 8'hA5);
    wr(A_PIN_HI, 8'h03);
    @(negedge clk_sys);
    chk(pin_digital_off, 12'h3A5);
    chk(pin_pullup_off, 12'h3A5);
    chk(pin_dir_override, 12'h3A5);

    // reference, gain and amplifier input for every code
    for (int r = 0; r < 4; r++) begin
      wr(A_CTRL_C, {r[0], 2'b00, r[1], r[1:0], r[1:0]}); // bandgap already on outside
      @(negedge clk_sys);
      chk({ref_avdd_sel, ref_pin_sel, ref_amp_sel}, {r == 0, r == 1, r[1]});
      chk(ref_pin_connect, r == 1);
      chk(gain_amp_enable, r[0]);
      chk(gain_amp_gain_select, r[1:0]);
      chk({amp_in_bandgap_sel, amp_in_pin_connect}, {r[1], ~r[1]});
    end

    // every source code against every channel code
    for (int s = 0; s < 16; s++) begin
      for (int c = 0; c < 16; c++) begin
        s4 = s[3:0];
        c4 = c[3:0];
        ext = (s4 == 4'h0) || (s4 == 4'h4) || (s4[3:2] == 2'b11);
        wr(A_CTRL_B, {s4, 4'h0});
        wr(A_CTRL_A, {4'h0, c4});
        @(negedge clk_sys);
        chk(chan_en, (ext && c < 12) ? (12'h001 << c) : 12'h000);
        chk({int_src_en, int_src_gnd}, {~ext, s4[3:2] == 2'b10});
        if (!ext && s4[3] == 1'b0) begin
          chk({int_src_amp, int_src_div}, s4[2:0]);
        end
      end
    end

    for (int i = 0; i < 8; i++) begin
      conv(i[2:0], i[0], 12'hFFF);
    end
    cmp_fix = 1'b0;
    conv(3'h1, 1'b0, 12'h000);
    model_on = 1'b1;
    conv(3'h4, 1'b1, vin);

    // restart and power-off abort in mid-conversion
    wr(A_STAT, 8'h01);
    wr(A_CTRL_A, 8'hA0);
    wr(A_CTRL_A, 8'h20);
    repeat (22) @(negedge clk_sys);
    rd(A_CTRL_A, d);
    chk(d, 8'h60);
    wr(A_CTRL_A, 8'hA0);
    repeat (2) @(negedge clk_sys);
    chk({conversion_busy_flag, irq_flag}, 2'b00);
    wr(A_CTRL_A, 8'h20);
    repeat (2) @(negedge clk_sys);
    chk(conversion_busy_flag, 1'b1);
    // clock enable low: power-off write ignored, conversion frozen
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(A_CTRL_A, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk({conversion_busy_flag, conv_power_en, sample_en}, 3'b111);
    @(posedge clk_sys);
    ce <= 1'b1;
    wr(A_CTRL_A, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk({conversion_busy_flag, conv_power_en, irq_flag}, 3'b000);
    end_of_test();
  end
endmodule // adc_input_ref_and_sequencing_bench
